// ===== bench/overvoltage_trip_elements_bench.sv
// self-checking bench for the overvoltage trip elements
`timescale 1ns/1ps

module overvoltage_trip_elements_bench;
    localparam int T = 20;                     // shortened 10 ms step, in cycles
    logic                            clk_sys = 1'b0;
    logic                            rst     = 1'b1;
    logic [7:0]                      addr    = 8'h00;
    logic [31:0]                     wdata   = 32'h0;
    logic                            wr      = 1'b0;
    logic                            rd      = 1'b0;
    logic [31:0]                     rdata;
    logic [6:0][ovt_pkg::VOLT_W-1:0] set_v   = '0;
    logic [ovt_pkg::VOLT_W-1:0]      va, vb, vc, vab, vbc, vca, vres;
    logic                            tpa, tpb, tga, tgb;
    wire  [3:0]                      trips   = {tgb, tga, tpb, tpa};
    int                              n_fail  = 0;
    int                              compares = 0;
    int                              n;

    // 200 MHz system clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    overvoltage_trip_elements #(.TICK_CYCLES(T)) overvoltage_trip_elements_i (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .volt_a(va), .volt_b(vb), .volt_c(vc), .volt_ab(vab),
        .volt_bc(vbc), .volt_ca(vca), .volt_residual(vres), .trip_phase_a(tpa),
        .trip_phase_b(tpb), .trip_ground_a(tga), .trip_ground_b(tgb));

    voltage_front_end_model voltage_front_end_model_i (
        .clk_sys(clk_sys), .rst(rst), .set_v(set_v), .volt_a(va), .volt_b(vb),
        .volt_c(vc), .volt_ab(vab), .volt_bc(vbc), .volt_ca(vca), .volt_residual(vres));

    // verdict and end of run, shared by the tests and the watchdog
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic chk1(string nm, logic e, logic g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    // a cycle count must land inside its window; -1 means it never came
    task automatic chk_rng(string nm, int lo, int hi, int g);
        compares++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    // one-cycle write strobe
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    // read strobe, data sampled in the cycle after the one it stands
    task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk32(nm, e, rdata);
    endtask : rd_chk

    task automatic setv(int i, logic [ovt_pkg::VOLT_W-1:0] v);
        @(posedge clk_sys);
        set_v[i] <= v;
    endtask : setv

    task automatic idle(int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : idle

    // cycles until a trip rises, bounded
    task automatic wait_rise(int i, int lim, output int c);
        c = 0;
        #1;
        while (trips[i] !== 1'b1 && c < lim) begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        if (trips[i] !== 1'b1) c = -1;
    endtask : wait_rise

    // cycles a trip stays high, bounded
    task automatic hold_len(int i, int lim, output int c);
        c = 0;
        #1;
        while (trips[i] === 1'b1 && c < lim) begin
            @(posedge clk_sys);
            #1;
            c++;
        end
    endtask : hold_len

    // watchdog, well beyond the few thousand cycles the tests need
    initial begin
        #(20000 * 5);
        n_fail++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, saturation of operate time, unmapped read
        rd_chk("ctrl", ovt_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd_chk("thr", ovt_pkg::REG_THR_BASE + 8'(4 * i),
                   (i < 2) ? 32'(ovt_pkg::PH_THR_RST) : 32'(ovt_pkg::GF_THR_RST));
            rd_chk("time", ovt_pkg::REG_TIME_BASE + 8'(4 * i), 32'h0);
        end
        rd_chk("unmapped", 8'h30, 32'h0);
        wr_reg(ovt_pkg::REG_TIME_BASE, 32'h7FF);
        rd_chk("time_sat", ovt_pkg::REG_TIME_BASE, 32'h3E8);
        wr_reg(ovt_pkg::REG_TIME_BASE, 32'h0);
        // threshold write lands; an unaligned write beside it is ignored
        wr_reg(ovt_pkg::REG_THR_BASE + 8'h04, 32'h7D0);
        wr_reg(ovt_pkg::REG_THR_BASE + 8'h05, 32'h123);
        rd_chk("thr_wr", ovt_pkg::REG_THR_BASE + 8'h04, 32'h7D0);
        rd_chk("thr_unaligned", ovt_pkg::REG_THR_BASE + 8'h05, 32'h0);
        wr_reg(ovt_pkg::REG_THR_BASE + 8'h04, 32'(ovt_pkg::PH_THR_RST));
        $display("test registers done");

        // unit a instantaneous, strict threshold, status, drop-off hold
        wr_reg(ovt_pkg::REG_CTRL, 32'h1);
        setv(0, 12'h4B0);
        idle(10);
        chk1("trip_pa_equal", 1'b0, tpa);
        setv(0, 12'h4B1);
        wait_rise(0, 10, n);
        chk_rng("pa_inst", 1, 4, n);
        // pickups are live for disabled units too: va tops both phase thresholds,
        // and a third of it tops both ground thresholds
        rd_chk("status", ovt_pkg::REG_STATUS, 32'hF1);
        setv(0, 12'h0);
        hold_len(0, 30 * T, n);
        chk_rng("pa_hold", 20 * T, 21 * T + 4, n);
        $display("test phase_a done");

        // lock of phase a, OR of the others, enable off
        wr_reg(ovt_pkg::REG_CTRL, 32'h101);
        setv(0, 12'h4B1);
        idle(10);
        chk1("trip_pa_locked", 1'b0, tpa);
        setv(1, 12'h4B1);
        wait_rise(0, 10, n);
        chk_rng("pa_phase_b", 1, 4, n);
        wr_reg(ovt_pkg::REG_CTRL, 32'h100);
        idle(3);
        chk1("trip_pa_disabled", 1'b0, tpa);
        setv(0, 12'h0);
        setv(1, 12'h0);
        $display("test lock_enable done");

        // unit b on line voltage with a timer, then restart on dropout
        wr_reg(ovt_pkg::REG_TIME_BASE + 8'h04, 32'h3);
        wr_reg(ovt_pkg::REG_CTRL, 32'h22);
        setv(0, 12'h4B1);
        idle(4 * T);
        chk1("trip_pb_phase_v", 1'b0, tpb);
        setv(0, 12'h0);
        setv(3, 12'h4B1);
        wait_rise(1, 4 * T + 10, n);
        chk_rng("pb_timer", 2 * T, 3 * T + 4, n);
        setv(3, 12'h0);
        hold_len(1, 30 * T, n);
        chk_rng("pb_hold", 20 * T, 21 * T + 4, n);
        setv(3, 12'h4B1);
        idle(3 * T / 2);
        setv(3, 12'h0);
        idle(2);
        setv(3, 12'h4B1);
        wait_rise(1, 4 * T + 10, n);
        chk_rng("pb_restart", 2 * T, 3 * T + 4, n);
        wr_reg(ovt_pkg::REG_CTRL, 32'h0);
        setv(3, 12'h0);
        $display("test phase_b done");

        // ground a on summed phases, ground b on residual with a timer
        wr_reg(ovt_pkg::REG_TIME_BASE + 8'h0C, 32'h2);
        wr_reg(ovt_pkg::REG_CTRL, 32'h8C);
        setv(0, 12'h258);
        idle(10);
        chk1("trip_ga_equal", 1'b0, tga);
        setv(0, 12'h25B);
        wait_rise(2, 10, n);
        chk_rng("ga_inst", 1, 4, n);
        chk1("trip_gb_no_residual", 1'b0, tgb);
        setv(6, 12'h0C9);
        wait_rise(3, 3 * T + 10, n);
        chk_rng("gb_timer", T, 2 * T + 4, n);
        wr_reg(ovt_pkg::REG_CTRL, 32'h88);
        idle(3);
        chk1("trip_ga_disabled", 1'b0, tga);
        setv(6, 12'h0);
        hold_len(3, 30 * T, n);
        chk_rng("gb_hold", 20 * T, 21 * T + 4, n);
        $display("test ground done");

        // all phases of unit a locked, ground a moved to the residual input
        wr_reg(ovt_pkg::REG_CTRL, 32'h745);
        rd_chk("ctrl_wr", ovt_pkg::REG_CTRL, 32'h745);
        setv(1, 12'h4B1);
        idle(10);
        chk1("trip_pa_all_locked", 1'b0, tpa);
        chk1("trip_ga_residual_low", 1'b0, tga);
        setv(6, 12'h0C9);
        wait_rise(2, 10, n);
        chk_rng("ga_residual", 1, 4, n);
        $display("test source_lock done");
        end_of_test();
    end
endmodule : overvoltage_trip_elements_bench

// ===== bench/voltage_front_end_model.sv
// behavioural model of the voltage measurement front end feeding the trip elements
`timescale 1ns/1ps

module voltage_front_end_model (
    // clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    // requested magnitudes: a, b, c, ab, bc, ca, residual
    input  wire logic [6:0][ovt_pkg::VOLT_W-1:0] set_v,
    // measured magnitudes, 0.1 V units
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_a,
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_b,
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_c,
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_ab,
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_bc,
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_ca,
    output logic      [ovt_pkg::VOLT_W-1:0]      volt_residual
);
    // one cycle of measurement latency, like a real sampling path
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {volt_a, volt_b, volt_c, volt_ab, volt_bc, volt_ca, volt_residual} <= '0;
        end else begin
            {volt_residual, volt_ca, volt_bc, volt_ab, volt_c, volt_b, volt_a} <= set_v;
        end
    end
endmodule : voltage_front_end_model

// ===== logic/overvoltage_trip_elements.sv
// two phase and two ground-fault overvoltage trip elements with register port
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

module overvoltage_trip_elements #(
    parameter int TICK_CYCLES = ovt_pkg::TICK_CYCLES_DEF  // clock cycles per 10 ms step
) (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // register port
    input  wire logic [ovt_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [31:0]                rdata,
    // phase-to-neutral voltages, 0.1 V units
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_a,
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_b,
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_c,
    // phase-to-phase voltages, 0.1 V units
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_ab,
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_bc,
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_ca,
    // residual_voltage_terminal, 0.1 V units
    input  wire logic [ovt_pkg::VOLT_W-1:0] volt_residual,
    // trip outputs to contact logic
    output logic                            trip_phase_a,
    output logic                            trip_phase_b,
    output logic                            trip_ground_a,
    output logic                            trip_ground_b
);
    localparam int NU    = ovt_pkg::NUM_UNITS;
    localparam int TCK_W = $clog2(TICK_CYCLES + 1);

    // refuse a timebase that cannot count
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end

    // settings
    logic [ovt_pkg::CTRL_W-1:0] ctrl_q;                 // enables, selects, locks
    logic [ovt_pkg::VOLT_W-1:0] thr_q  [NU];            // thresholds per unit
    logic [ovt_pkg::TIME_W-1:0] time_q [NU];            // operate times per unit
    // timebase
    logic [TCK_W-1:0]           tick_cnt_q;             // prescaler
    logic                       tick;                   // one cycle every 10 ms
    // per-unit state
    logic [ovt_pkg::TIME_W-1:0] op_cnt_q  [NU];         // operate timer
    logic [ovt_pkg::TIME_W-1:0] op_cnt_d  [NU];
    logic [NU-1:0]              op_done_q;              // timer expired
    logic [NU-1:0]              op_done_d;
    logic [ovt_pkg::DROP_W-1:0] drop_q    [NU];         // off-delay counter
    logic [ovt_pkg::DROP_W-1:0] drop_d    [NU];
    logic [NU-1:0]              trip_q;                 // registered trip
    logic [NU-1:0]              trip_d;
    logic [NU-1:0]              pickup;                 // level over threshold
    logic [NU-1:0]              unit_en;
    // measurement selection
    logic [ovt_pkg::VOLT_W-1:0] phase_v [3];
    logic [ovt_pkg::VOLT_W-1:0] line_v  [3];
    logic [ovt_pkg::VOLT_W+1:0] sum3;                   // va+vb+vc
    logic [ovt_pkg::VOLT_W-1:0] zero_seq_sum;           // summed_phases_method result
    logic [ovt_pkg::VOLT_W-1:0] zero_seq [2];           // per ground unit
    logic [2:0]                 phase_lock [2];         // unit b never locks
    logic [2:0]                 phase_hit  [2];
    logic [31:0]                rdata_q;
    logic [31:0]                rdata_d;
    logic [31:0]                status_word;

    assign phase_v[0] = volt_a;
    assign phase_v[1] = volt_b;
    assign phase_v[2] = volt_c;
    assign line_v[0]  = volt_ab;
    assign line_v[1]  = volt_bc;
    assign line_v[2]  = volt_ca;
    assign unit_en    = ctrl_q[ovt_pkg::CTRL_EN_LSB +: NU];

    // zero sequence magnitude as a third of the summed phases
    assign sum3         = {2'h0, volt_a} + {2'h0, volt_b} + {2'h0, volt_c};
    assign zero_seq_sum = ovt_pkg::VOLT_W'(sum3 / 14'h0003);

    // lock bits belong to phase unit a only
    assign phase_lock[0] = ctrl_q[ovt_pkg::CTRL_LOCK_LSB +: 3];
    assign phase_lock[1] = 3'h0;

    // phase units: per-phase compare then OR of unlocked phases
    for (genvar u = 0; u < 2; u++) begin : g_phase
        for (genvar p = 0; p < 3; p++) begin : g_ph
            logic [ovt_pkg::VOLT_W-1:0] v_sel;
            // line_voltage_method when the select bit is set
            assign v_sel = ctrl_q[ovt_pkg::CTRL_SEL_LSB + u] ? line_v[p] : phase_v[p];
            assign phase_hit[u][p] = (v_sel > thr_q[u]) && !phase_lock[u][p];
        end
        assign pickup[u] = |phase_hit[u];
    end

    // ground units: source select then compare
    for (genvar g = 0; g < 2; g++) begin : g_ground
        // residual_input_method when the source bit is set
        assign zero_seq[g] = ctrl_q[ovt_pkg::CTRL_SRC_LSB + g] ? volt_residual
                                                                : zero_seq_sum;
        assign pickup[ovt_pkg::UNIT_GF_A + g] =
            zero_seq[g] > thr_q[ovt_pkg::UNIT_GF_A + g];
    end

    // 10 ms timebase shared by all units
    assign tick = (tick_cnt_q == TCK_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // identical timer and off-delay per unit; enable gates everything
    for (genvar i = 0; i < NU; i++) begin : g_unit
        always_comb begin
            op_cnt_d[i]  = op_cnt_q[i];
            op_done_d[i] = op_done_q[i];
            drop_d[i]    = drop_q[i];
            if (!unit_en[i]) begin
                // disabled: nothing runs, nothing held
                op_cnt_d[i]  = '0;
                op_done_d[i] = 1'b0;
                drop_d[i]    = '0;
            end else if (pickup[i]) begin
                // zero time expires in the first cycle of pickup
                if (op_cnt_q[i] >= time_q[i]) begin
                    op_done_d[i] = 1'b1;
                end else if (tick) begin
                    op_cnt_d[i] = op_cnt_q[i] + 1'b1;
                end
                // load on expiry itself, so a trip whose pickup ends at once still gets
                // the full hold instead of a one-cycle pulse
                if (op_done_d[i]) begin
                    drop_d[i] = ovt_pkg::DROP_W'(ovt_pkg::DROPOFF_LOAD);
                end
            end else begin
                // dropout restarts the operate timer from zero
                op_cnt_d[i]  = '0;
                op_done_d[i] = 1'b0;
                if (drop_q[i] != '0 && tick) begin
                    drop_d[i] = drop_q[i] - 1'b1;
                end
            end
            trip_d[i] = unit_en[i] && (op_done_d[i] || drop_d[i] != '0);
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                op_cnt_q[i]  <= '0;
                op_done_q[i] <= 1'b0;
                drop_q[i]    <= '0;
                trip_q[i]    <= 1'b0;
            end else begin
                op_cnt_q[i]  <= op_cnt_d[i];
                op_done_q[i] <= op_done_d[i];
                drop_q[i]    <= drop_d[i];
                trip_q[i]    <= trip_d[i];
            end
        end

        // disabled unit never trips one cycle later
        property p_trip_off_disabled;
            @(posedge clk_sys) disable iff (rst)
            !unit_en[i] |=> !trip_q[i];
        endproperty
        a_trip_off_disabled: assert property (p_trip_off_disabled)
            else $error("trip asserted while unit disabled");

        // zero operate time trips within two cycles of steady pickup
        property p_inst_trip;
            @(posedge clk_sys) disable iff (rst)
            (unit_en[i] && pickup[i] && time_q[i] == '0) [*2] |=> trip_q[i];
        endproperty
        a_inst_trip: assert property (p_inst_trip)
            else $error("instantaneous trip missing");

        // a trip only starts from a live pickup
        property p_trip_cause;
            @(posedge clk_sys) disable iff (rst)
            $rose(trip_q[i]) |-> $past(pickup[i]) && $past(unit_en[i]);
        endproperty
        a_trip_cause: assert property (p_trip_cause)
            else $error("trip rose without pickup");

        // trip held after pickup drops while enable stays on
        property p_dropoff_hold;
            @(posedge clk_sys) disable iff (rst)
            (trip_q[i] && !pickup[i] && unit_en[i] && !tick && $past(op_done_q[i]))
                |=> trip_q[i] || !unit_en[i];
        endproperty
        a_dropoff_hold: assert property (p_dropoff_hold)
            else $error("trip released without off-delay");

        // timer cleared after a dropout
        property p_timer_restart;
            @(posedge clk_sys) disable iff (rst)
            !pickup[i] |=> op_cnt_q[i] == '0 && !op_done_q[i];
        endproperty
        a_timer_restart: assert property (p_timer_restart)
            else $error("operate timer not restarted");

        // timer never trips early: done implies count reached setting
        property p_no_early;
            @(posedge clk_sys) disable iff (rst)
            $rose(op_done_q[i]) |-> $past(op_cnt_q[i]) >= $past(time_q[i]);
        endproperty
        a_no_early: assert property (p_no_early)
            else $error("operate timer expired early");

        c_trip: cover property (@(posedge clk_sys) disable iff (rst) $rose(trip_q[i]));
        c_release: cover property (@(posedge clk_sys) disable iff (rst) $fell(trip_q[i]));
    end

    // fully locked unit a cannot pick up
    property p_lock_all;
        @(posedge clk_sys) disable iff (rst)
        (&phase_lock[0]) |-> !pickup[ovt_pkg::UNIT_PH_A];
    endproperty
    a_lock_all: assert property (p_lock_all)
        else $error("locked phases picked up");

    // phase method on unit b follows phase a voltage
    property p_phase_method;
        @(posedge clk_sys) disable iff (rst)
        (!ctrl_q[ovt_pkg::CTRL_SEL_LSB + 1] && volt_a > thr_q[ovt_pkg::UNIT_PH_B])
            |-> pickup[ovt_pkg::UNIT_PH_B];
    endproperty
    a_phase_method: assert property (p_phase_method)
        else $error("phase voltage over threshold not picked up");

    // residual source compares the residual input directly
    property p_residual;
        @(posedge clk_sys) disable iff (rst)
        ctrl_q[ovt_pkg::CTRL_SRC_LSB] |->
            pickup[ovt_pkg::UNIT_GF_A] == (volt_residual > thr_q[ovt_pkg::UNIT_GF_A]);
    endproperty
    a_residual: assert property (p_residual)
        else $error("ground pickup disagrees with residual input");

    c_lock_use: cover property (@(posedge clk_sys) disable iff (rst)
        phase_lock[0] != 3'h0 && pickup[ovt_pkg::UNIT_PH_A]);

    // register decode
    logic       wr_ctrl;
    logic       hit_thr;
    logic       hit_time;
    logic [7:0] thr_off;
    logic [7:0] time_off;
    logic [1:0] thr_idx;
    logic [1:0] time_idx;

    assign thr_off  = addr - ovt_pkg::REG_THR_BASE;
    assign time_off = addr - ovt_pkg::REG_TIME_BASE;
    assign hit_thr  = addr >= ovt_pkg::REG_THR_BASE && addr < ovt_pkg::REG_TIME_BASE
                      && addr[1:0] == 2'h0;
    assign hit_time = addr >= ovt_pkg::REG_TIME_BASE && addr < ovt_pkg::REG_STATUS
                      && addr[1:0] == 2'h0;
    assign thr_idx  = thr_off[3:2];
    assign time_idx = time_off[3:2];
    assign wr_ctrl  = wr && addr == ovt_pkg::REG_CTRL;

    // status shows live trips and pickups
    assign status_word = {24'h000000, pickup, trip_q};

    // read mux; unmapped addresses read zero
    assign rdata_d = (addr == ovt_pkg::REG_CTRL)   ? {21'h000000, ctrl_q} :
                     hit_thr                       ? {20'h00000, thr_q[thr_idx]} :
                     hit_time                      ? {22'h000000, time_q[time_idx]} :
                     (addr == ovt_pkg::REG_STATUS) ? status_word : 32'h00000000;

    // settings registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= ovt_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata[ovt_pkg::CTRL_W-1:0];
        end
    end

    for (genvar r = 0; r < NU; r++) begin : g_set
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                thr_q[r]  <= (r < 2) ? ovt_pkg::PH_THR_RST : ovt_pkg::GF_THR_RST;
                time_q[r] <= ovt_pkg::TIME_RST;
            end else begin
                if (wr && hit_thr && thr_idx == 2'(r)) begin
                    thr_q[r] <= wdata[ovt_pkg::VOLT_W-1:0];
                end
                // times above 10.00 s saturate
                if (wr && hit_time && time_idx == 2'(r)) begin
                    time_q[r] <= (wdata[ovt_pkg::TIME_W-1:0] > ovt_pkg::TIME_MAX)
                                 ? ovt_pkg::TIME_MAX : wdata[ovt_pkg::TIME_W-1:0];
                end
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd ? rdata_d : 32'h00000000;
        end
    end

    assign rdata         = rdata_q;
    assign trip_phase_a  = trip_q[ovt_pkg::UNIT_PH_A];
    assign trip_phase_b  = trip_q[ovt_pkg::UNIT_PH_B];
    assign trip_ground_a = trip_q[ovt_pkg::UNIT_GF_A];
    assign trip_ground_b = trip_q[ovt_pkg::UNIT_GF_B];
endmodule : overvoltage_trip_elements

// ===== logic/ovt_pkg.sv
// package of constants for the overvoltage trip elements
package ovt_pkg;
    // clock and timebase
    localparam int CLK_MHZ          = 200;     // system clock rate
    localparam int TICK_MS          = 10;      // timer step, one setting lsb of operate time
    localparam int TICK_CYCLES_DEF  = TICK_MS * CLK_MHZ * 1000;
    localparam int DROPOFF_MS       = 200;     // trip hold after pickup clears
    localparam int DROPOFF_TICKS    = DROPOFF_MS / TICK_MS;
    // one extra tick so the hold never falls short of the full time
    localparam int DROPOFF_LOAD     = DROPOFF_TICKS + 1;
    localparam int INST_MS          = 50;      // instantaneous trip limit
    // widths
    localparam int VOLT_W           = 12;      // voltage in 0.1 V units
    localparam int TIME_W           = 10;      // operate time in 0.01 s units
    localparam int DROP_W           = 5;
    localparam int ADDR_W           = 8;
    localparam int NUM_UNITS        = 4;       // phase a, phase b, ground a, ground b
    // unit indices
    localparam int UNIT_PH_A        = 0;
    localparam int UNIT_PH_B        = 1;
    localparam int UNIT_GF_A        = 2;
    localparam int UNIT_GF_B        = 3;
    // register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_THR_BASE  = 8'h04;  // four thresholds, one word each
    localparam logic [7:0] REG_TIME_BASE = 8'h14;  // four operate times, one word each
    localparam logic [7:0] REG_STATUS    = 8'h24;
    // control field positions
    localparam int CTRL_EN_LSB      = 0;       // four enables
    localparam int CTRL_SEL_LSB     = 4;       // line_voltage_method for phase a, b
    localparam int CTRL_SRC_LSB     = 6;       // residual_input_method for ground a, b
    localparam int CTRL_LOCK_LSB    = 8;       // phase a locks, phases a..c
    localparam int CTRL_W           = 11;
    // status field positions
    localparam int STAT_TRIP_LSB    = 0;
    localparam int STAT_PICK_LSB    = 4;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 11'h000;
    localparam logic [VOLT_W-1:0] PH_THR_RST = 12'h4B0;  // 120.0 V
    localparam logic [VOLT_W-1:0] GF_THR_RST = 12'h0C8;  // 20.0 V
    localparam logic [TIME_W-1:0] TIME_RST   = 10'h000;
    localparam logic [TIME_W-1:0] TIME_MAX   = 10'h3E8;  // 10.00 s
endpackage : ovt_pkg
